//--- mhpc_dev.sv
// Device end: host register port, byte clock sampling and client datapath stubs
`timescale 1ns/100ps
module mhpc_dev (
  input wire logic clk,
  input wire logic rst_n,
  mhpc_if.dev bus,
  output logic [7:0] txByte,
  output logic txByteValid,
  output logic txFrameEnd,
  output logic adaptMode
);
  // Link pins sampled from outside the host clock domain
  localparam int NSYNC = 15;
  localparam int I_RX = 0;
  localparam int I_TX = 1;
  localparam int I_MDC = 2;
  localparam int I_RXEN = 3;
  localparam int I_TXEN = 4;
  localparam int I_AV = 5;
  localparam int I_EOF = 6;
  localparam int I_DAT = 7;

  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] pinMeta;
  logic [NSYNC-1:0] pinSync;
  logic [2:0] clkPrev;
  logic rxRise;
  logic txRise;
  logic mdcRise;
  logic rxAdvance;
  logic txAdvance;
  mhpc_pkg::mhpc_dstate_t state;
  logic readOp;
  logic [7:0] modeReg;
  logic [7:0] txCount;
  logic [7:0] txLast;
  logic [7:0] rxSeed;
  logic [7:0] rxCount;
  logic [7:0] mdcCount;
  logic [7:0] readMux;
  logic csActive;
  logic strobesIdle;

  assign pinRaw = {bus.txData, bus.txEof, bus.txAvail, bus.txmacClkEn, bus.rxmacClkEn,
                   bus.mdc, bus.txmacClk, bus.rxmacClk};

  // Two flops on every link pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // Previous clock levels for edge finding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev <= '0;
    end else begin
      clkPrev <= pinSync[I_MDC:I_RX];
    end
  end

  assign rxRise = pinSync[I_RX] & ~clkPrev[I_RX];
  assign txRise = pinSync[I_TX] & ~clkPrev[I_TX];
  assign mdcRise = pinSync[I_MDC] & ~clkPrev[I_MDC];
  assign adaptMode = modeReg[mhpc_pkg::MODE_ADAPT];

  // Enables only count in adapter mode
  assign rxAdvance = rxRise & (~adaptMode | pinSync[I_RXEN]); // R10 R23
  assign txAdvance = txRise & (~adaptMode | pinSync[I_TXEN]); // R10 R23

  // Select gates both strobes
  assign csActive = ~bus.hcsN; // R13
  assign strobesIdle = bus.hwriteN & bus.hreadN;

  // Host transfer sequencer on the host clock
  always_ff @(posedge clk or negedge rst_n) begin // R6 R8
    if (!rst_n) begin
      state <= mhpc_pkg::ST_IDLE;
      readOp <= 1'b0;
    end else begin
      case (state)
        mhpc_pkg::ST_IDLE: begin
          if (csActive && !bus.hwriteN) begin // R13 R16
            state <= mhpc_pkg::ST_WRITE;
            readOp <= 1'b0;
          end else if (csActive && !bus.hreadN) begin // R13 R17
            state <= mhpc_pkg::ST_READ;
            readOp <= 1'b1;
          end
        end
        mhpc_pkg::ST_WRITE: state <= mhpc_pkg::ST_DONE;
        mhpc_pkg::ST_READ: state <= mhpc_pkg::ST_DONE;
        mhpc_pkg::ST_DONE: begin
          if (strobesIdle || bus.hcsN) begin
            state <= mhpc_pkg::ST_IDLE;
            readOp <= 1'b0;
          end
        end
        default: state <= mhpc_pkg::ST_IDLE;
      endcase
    end
  end

  // Ready after the store or read data load
  assign bus.hreadyN = ~(state == mhpc_pkg::ST_DONE); // R18 R19 R20 R9
  assign bus.hdataoutEnN = ~((state == mhpc_pkg::ST_DONE) & readOp); // R22 R9

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin // R8
    if (!rst_n) begin
      modeReg <= mhpc_pkg::MODE_RESET;
      rxSeed <= mhpc_pkg::ZERO8;
    end else if (state == mhpc_pkg::ST_WRITE) begin // R16
      case (bus.haddr)
        mhpc_pkg::ADDR_MODE: modeReg <= bus.hdatain;
        mhpc_pkg::ADDR_RXSEED: rxSeed <= bus.hdatain;
        default: ;
      endcase
    end
  end

  // Read selection, unmapped reads as zero
  always_comb begin
    case (bus.haddr)
      mhpc_pkg::ADDR_MODE: readMux = modeReg;
      mhpc_pkg::ADDR_TXCNT: readMux = txCount;
      mhpc_pkg::ADDR_TXLAST: readMux = txLast;
      mhpc_pkg::ADDR_RXSEED: readMux = rxSeed;
      mhpc_pkg::ADDR_MDCCNT: readMux = mdcCount;
      default: readMux = mhpc_pkg::ZERO8;
    endcase
  end

  // Read data loaded on the same edge that asserts ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.hdataout <= mhpc_pkg::ZERO8;
    end else if (state == mhpc_pkg::ST_READ) begin
      bus.hdataout <= readMux; // R17 R20 R21
    end
  end

  // Gigabit indication mirrors mode bit 0
  assign bus.gbitEn = modeReg[mhpc_pkg::MODE_GBIT]; // R12 R9

  // Transmit client byte capture on tx byte clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txCount <= mhpc_pkg::ZERO8;
      txLast <= mhpc_pkg::ZERO8;
      txByte <= mhpc_pkg::ZERO8;
      txByteValid <= 1'b0;
      txFrameEnd <= 1'b0;
    end else begin
      txByteValid <= 1'b0;
      txFrameEnd <= 1'b0;
      if (txAdvance && pinSync[I_AV]) begin // R3 R23
        txByte <= pinSync[I_DAT +: 8];
        txLast <= pinSync[I_DAT +: 8];
        txCount <= txCount + mhpc_pkg::ONE8;
        txByteValid <= 1'b1;
        txFrameEnd <= pinSync[I_EOF];
      end
    end
  end

  // Receive client outputs change only at rx byte clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCount <= mhpc_pkg::ZERO8;
      bus.rxData <= mhpc_pkg::ZERO8;
      bus.rxValid <= 1'b0;
    end else if (rxAdvance) begin // R1 R23
      bus.rxValid <= modeReg[mhpc_pkg::MODE_RXEN];
      bus.rxData <= rxSeed + rxCount;
      if (modeReg[mhpc_pkg::MODE_RXEN]) begin
        rxCount <= rxCount + mhpc_pkg::ONE8;
      end
    end
  end

  // Management clock edge count, idle when module absent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdcCount <= mhpc_pkg::ZERO8;
    end else if (mhpc_pkg::MGMT_BUILT && mdcRise) begin // R7
      mdcCount <= mdcCount + mhpc_pkg::ONE8;
    end
  end
endmodule

//--- mhpc_pkg.sv
// Shared constants, types and rule summary for the MAC host port and clocking block
// Contract
// R1: Rx client outputs change on rx byte clock
// R2: Byte clocks 125, 12.5, 1.25 MHz by speed
// R3: Tx client inputs aligned to tx byte clock
// R4: Serial adapter option keeps byte clocks fixed
// R5: Tx clock from system/PHY, rx from PHY
// R6: Host port logic runs on host clock
// R7: Management clock used only when module built
// R8: Reset is asynchronous active low, clears all
// R9: Outputs inactive while reset asserted
// R10: Clock enables honoured only in adapter option
// R11: Enables high at 1G, 1/10, 1/100 otherwise
// R12: Gigabit output mirrors mode register bit 0
// R13: Strobes ignored while select is high
// R14: Host drives 8-bit register address
// R15: Host drives 8-bit write data
// R16: Write strobe stores data into addressed register
// R17: Read strobe returns addressed register contents
// R18: Ready low marks end of each transfer
// R19: Write ready only after data is stored
// R20: Read ready only once read data prepared
// R21: Read data on separate 8-bit output bus
// R22: Data enable low while read data valid
// R23: Adapter option advances only on enabled cycles
// R24: Host holds request until ready, then releases
package mhpc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TXCNT = 8'h01;
  localparam logic [7:0] ADDR_TXLAST = 8'h02;
  localparam logic [7:0] ADDR_RXSEED = 8'h03;
  localparam logic [7:0] ADDR_MDCCNT = 8'h04;
  // Mode register fields
  localparam int MODE_GBIT = 0;
  localparam int MODE_ADAPT = 1;
  localparam int MODE_RXEN = 2;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  // Management interface present
  localparam bit MGMT_BUILT = 1'b1;
  // Byte clock half periods in host clocks, ten times apart per speed, then the management clock half period
  localparam logic [8:0] HALF_1G = 9'h004;
  localparam logic [8:0] HALF_100 = 9'h028;
  localparam logic [8:0] HALF_10 = 9'h190;
  localparam logic [8:0] HALF_MDC = 9'h008;
  // Clock enable spacing in byte clocks
  localparam logic [6:0] ENA_100 = 7'h0a;
  localparam logic [6:0] ENA_10 = 7'h64;
  typedef enum logic [1:0] {SPD_1G, SPD_100, SPD_10} mhpc_speed_t;
  typedef enum {ST_IDLE, ST_WRITE, ST_READ, ST_DONE} mhpc_dstate_t;
  typedef enum {H_IDLE, H_WAIT, H_REL} mhpc_hstate_t;
endpackage

//--- mhpc_if.sv
// Interface joining the device end and the host end
`timescale 1ns/100ps
interface mhpc_if;
  logic hcsN;
  logic [7:0] haddr;
  logic [7:0] hdatain;
  logic hwriteN;
  logic hreadN;
  logic hreadyN;
  logic [7:0] hdataout;
  logic hdataoutEnN;
  logic rxmacClk;
  logic txmacClk;
  logic mdc;
  logic txmacClkEn;
  logic rxmacClkEn;
  logic [7:0] txData;
  logic txAvail;
  logic txEof;
  logic [7:0] rxData;
  logic rxValid;
  logic gbitEn;
  modport dev (
    input hcsN, haddr, hdatain, hwriteN, hreadN, rxmacClk, txmacClk, mdc,
    input txmacClkEn, rxmacClkEn, txData, txAvail, txEof,
    output hreadyN, hdataout, hdataoutEnN, rxData, rxValid, gbitEn
  );
  modport host (
    output hcsN, haddr, hdatain, hwriteN, hreadN, rxmacClk, txmacClk, mdc,
    output txmacClkEn, rxmacClkEn, txData, txAvail, txEof,
    input hreadyN, hdataout, hdataoutEnN, rxData, rxValid, gbitEn
  );
endinterface

//--- mhpc_host.sv
// Host end: register port master, byte clock and enable source, tx client
`timescale 1ns/100ps
module mhpc_host (
  input wire logic clk,
  input wire logic rst_n,
  mhpc_if.host bus,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData,
  input wire logic [1:0] speed,
  input wire logic adaptMode,
  input wire logic txValid,
  input wire logic [7:0] txByteIn,
  input wire logic txEofIn,
  output logic txTaken,
  output logic [7:0] rxByte,
  output logic rxStrobe
);
  mhpc_pkg::mhpc_hstate_t state;
  logic [8:0] divCount;
  logic [8:0] halfLen;
  logic [8:0] mdcCount;
  logic byteClk;
  logic byteFall;
  logic [6:0] enaCount;
  logic [6:0] enaLen;
  logic enaNow;

  // Bus master sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mhpc_pkg::H_IDLE;
      bus.hcsN <= 1'b1;
      bus.hwriteN <= 1'b1;
      bus.hreadN <= 1'b1;
      bus.haddr <= mhpc_pkg::ZERO8;
      bus.hdatain <= mhpc_pkg::ZERO8;
      rspValid <= 1'b0;
      rspData <= mhpc_pkg::ZERO8;
    end else begin
      rspValid <= 1'b0;
      case (state)
        mhpc_pkg::H_IDLE: begin
          if (reqValid) begin
            bus.hcsN <= 1'b0; // R13
            bus.haddr <= reqAddr; // R14
            bus.hdatain <= reqWdata; // R15
            bus.hwriteN <= ~reqWrite; // R16
            bus.hreadN <= reqWrite; // R17
            state <= mhpc_pkg::H_WAIT;
          end
        end
        mhpc_pkg::H_WAIT: begin
          if (!bus.hreadyN) begin // R24
            rspData <= bus.hdataoutEnN ? mhpc_pkg::ZERO8 : bus.hdataout;
            rspValid <= 1'b1;
            bus.hcsN <= 1'b1;
            bus.hwriteN <= 1'b1;
            bus.hreadN <= 1'b1;
            state <= mhpc_pkg::H_REL;
          end
        end
        mhpc_pkg::H_REL: begin
          if (bus.hreadyN) begin
            state <= mhpc_pkg::H_IDLE;
          end
        end
        default: state <= mhpc_pkg::H_IDLE;
      endcase
    end
  end

  assign reqReady = (state == mhpc_pkg::H_IDLE);

  // Byte clock rate by speed, fixed in adapter mode
  always_comb begin
    if (adaptMode || speed == mhpc_pkg::SPD_1G) begin // R2 R4
      halfLen = mhpc_pkg::HALF_1G;
    end else if (speed == mhpc_pkg::SPD_100) begin
      halfLen = mhpc_pkg::HALF_100;
    end else begin
      halfLen = mhpc_pkg::HALF_10;
    end
    enaLen = (speed == mhpc_pkg::SPD_100) ? mhpc_pkg::ENA_100 : mhpc_pkg::ENA_10;
  end

  assign byteFall = byteClk && (divCount == halfLen - 9'h001);

  // Byte clock divider, one source for both directions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= '0;
      byteClk <= 1'b0;
    end else if (divCount >= halfLen - 9'h001) begin
      divCount <= '0;
      byteClk <= ~byteClk; // R5
    end else begin
      divCount <= divCount + 9'h001;
    end
  end

  assign bus.txmacClk = byteClk;
  assign bus.rxmacClk = byteClk;
  assign enaNow = (speed == mhpc_pkg::SPD_1G) || (enaCount == '0);

  // Enable pulses, changed on byte clock fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enaCount <= '0;
      bus.txmacClkEn <= 1'b0;
      bus.rxmacClkEn <= 1'b0;
    end else if (byteFall) begin
      enaCount <= (enaCount >= enaLen - 7'h01) ? '0 : enaCount + 7'h01;
      bus.txmacClkEn <= enaNow; // R11
      bus.rxmacClkEn <= enaNow; // R11
    end
  end

  // Tx client data changes on fall, held across each rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.txData <= mhpc_pkg::ZERO8;
      bus.txAvail <= 1'b0;
      bus.txEof <= 1'b0;
      txTaken <= 1'b0;
      rxByte <= mhpc_pkg::ZERO8;
      rxStrobe <= 1'b0;
    end else begin
      txTaken <= 1'b0;
      rxStrobe <= 1'b0;
      if (byteFall && (!adaptMode || enaNow)) begin // R3
        bus.txAvail <= txValid;
        bus.txData <= txByteIn;
        bus.txEof <= txEofIn;
        txTaken <= txValid;
      end
      if (byteFall && bus.rxValid && (!adaptMode || bus.rxmacClkEn)) begin
        rxByte <= bus.rxData;
        rxStrobe <= 1'b1;
      end
    end
  end

  // Management clock divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdcCount <= '0;
      bus.mdc <= 1'b0;
    end else if (mdcCount >= mhpc_pkg::HALF_MDC - 9'h001) begin
      mdcCount <= '0;
      bus.mdc <= ~bus.mdc;
    end else begin
      mdcCount <= mdcCount + 9'h001;
    end
  end
endmodule

//--- mhpc_checker.sv
// Checker for the host register port and link signals between the two ends
`timescale 1ns/100ps
module mhpc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hcsN,
  input wire logic [7:0] haddr,
  input wire logic [7:0] hdatain,
  input wire logic hwriteN,
  input wire logic hreadN,
  input wire logic hreadyN,
  input wire logic hdataoutEnN,
  input wire logic gbitEn,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic txAvail
);
  default clocking cb @(posedge clk);
  endclocking
  // Request steps seen on the bus
  sequence s_wr;
    $fell(hwriteN) && !hcsN;
  endsequence
  sequence s_rd;
    $fell(hreadN) && !hcsN && hwriteN;
  endsequence
  sequence s_mode_wr;
    s_wr ##0 (haddr == mhpc_pkg::ADDR_MODE);
  endsequence
  // Ready two edges after a taken request
  property p_write_ready;
    disable iff (!rst_n) s_wr |-> hreadyN [*2] ##1 !hreadyN;
  endproperty
  a_write_ready: assert property (p_write_ready) else $error("write ready timing");
  property p_read_ready;
    disable iff (!rst_n) s_rd |-> (hreadyN && hdataoutEnN) [*2] ##1 (!hreadyN && !hdataoutEnN);
  endproperty
  a_read_ready: assert property (p_read_ready) else $error("read ready timing");
  // Answer withdrawn one edge after release
  property p_release;
    disable iff (!rst_n) $rose(hcsN) |=> hreadyN && hdataoutEnN;
  endproperty
  a_release: assert property (p_release) else $error("ready held after release");
  property p_en_read;
    disable iff (!rst_n) !hdataoutEnN |-> !$past(hreadN);
  endproperty
  a_en_read: assert property (p_en_read) else $error("data enable outside read");
  // Gigabit flag follows the written mode bit
  property p_gbit;
    disable iff (!rst_n) s_mode_wr |-> ##3 (($past(hdatain, 3) & 8'h01) == {7'h00, gbitEn});
  endproperty
  a_gbit: assert property (p_gbit) else $error("gbit flag not mirrored");
  property p_desel;
    disable iff (!rst_n) hcsN [*2] |-> hreadyN;
  endproperty
  a_desel: assert property (p_desel) else $error("ready while deselected");
  // Outputs idle while reset is held
  property p_reset_idle;
    !rst_n |-> hreadyN && hdataoutEnN && hcsN && hwriteN && hreadN && !gbitEn && !rxValid
      && !txAvail && (rxData == 8'h00);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("output active in reset");
  property p_rx_spacing;
    disable iff (!rst_n) $changed(rxData) |=> $stable(rxData) [*7];
  endproperty
  a_rx_spacing: assert property (p_rx_spacing) else $error("rx data off byte clock");
endmodule

//--- tb_mac_host_port_and_clocking.sv
// Testbench joining both ends, plus a second device driven directly
`timescale 1ns/100ps
module tb_mac_host_port_and_clocking;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [7:0] reqAddr = 8'h00;
  logic [7:0] reqWdata = 8'h00;
  logic [1:0] speed = 2'h0;
  logic adaptMode = 1'b0;
  logic txValid = 1'b0;
  logic [7:0] txByteIn = 8'h00;
  logic txEofIn = 1'b0;
  logic reqReady, rspValid, txTaken, rxStrobe, txByteValid, txFrameEnd, devAdapt;
  logic [7:0] rspData, rxByte, txByte;
  logic [8:0] txq[$];
  int nMismatch = 0;
  int checksDone = 0;
  int cycles = 0;
  mhpc_if bus();
  mhpc_if bus2();
  mhpc_dev mhpc_dev_i(.clk(clk), .rst_n(rst_n), .bus(bus.dev), .txByte(txByte),
    .txByteValid(txByteValid), .txFrameEnd(txFrameEnd), .adaptMode(devAdapt));
  mhpc_dev mhpc_dev_i2(.clk(clk), .rst_n(rst_n), .bus(bus2.dev), .txByte(), .txByteValid(),
    .txFrameEnd(), .adaptMode());
  mhpc_host mhpc_host_i(.clk(clk), .rst_n(rst_n), .bus(bus.host), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .speed(speed), .adaptMode(adaptMode),
    .txValid(txValid), .txByteIn(txByteIn), .txEofIn(txEofIn), .txTaken(txTaken),
    .rxByte(rxByte), .rxStrobe(rxStrobe));
  mhpc_checker mhpc_checker_i(.clk(clk), .rst_n(rst_n), .hcsN(bus.hcsN), .haddr(bus.haddr),
    .hdatain(bus.hdatain), .hwriteN(bus.hwriteN), .hreadN(bus.hreadN), .hreadyN(bus.hreadyN),
    .hdataoutEnN(bus.hdataoutEnN), .gbitEn(bus.gbitEn), .rxData(bus.rxData),
    .rxValid(bus.rxValid), .txAvail(bus.txAvail));
  // Second device shares the link pins of the first
  assign bus2.rxmacClk = bus.rxmacClk;
  assign bus2.txmacClk = bus.txmacClk;
  assign bus2.mdc = bus.mdc;
  assign bus2.txmacClkEn = bus.txmacClkEn;
  assign bus2.rxmacClkEn = bus.rxmacClkEn;
  assign bus2.txData = bus.txData;
  assign bus2.txAvail = bus.txAvail;
  assign bus2.txEof = bus.txEof;
  // Clock, cycle ceiling and tx byte capture
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      nMismatch++;
      tallyAndFinish();
    end
  end
  always @(negedge clk) begin
    if (txByteValid === 1'b1) txq.push_back({txFrameEnd, txByte});
  end
  // Comparison and verdict
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tallyAndFinish();
    $display("Checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One register transfer through the host end
  task automatic hreq(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqWdata = d;
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("rspValid", 8'h01, {7'h00, rspValid});
    q = rspData;
    repeat (3) @(negedge clk);
  endtask
  // Mode, seed, unmapped and management clock count accesses
  task automatic t_regs();
    logic [7:0] q, m;
    hreq(1'b1, mhpc_pkg::ADDR_MODE, 8'h01, q);
    chk("gbitEn", 8'h01, {7'h00, bus.gbitEn});
    hreq(1'b0, mhpc_pkg::ADDR_MODE, 8'h00, q);
    chk("mode", 8'h01, q);
    hreq(1'b1, mhpc_pkg::ADDR_RXSEED, 8'ha5, q);
    hreq(1'b0, mhpc_pkg::ADDR_RXSEED, 8'h00, q);
    chk("seed", 8'ha5, q);
    hreq(1'b0, 8'hff, 8'h00, q);
    chk("unmapped", 8'h00, q);
    hreq(1'b1, mhpc_pkg::ADDR_MODE, 8'h00, q);
    chk("gbitOff", 8'h00, {7'h00, bus.gbitEn});
    // Reads 40 clocks apart, management clock period 16 clocks
    hreq(1'b0, mhpc_pkg::ADDR_MDCCNT, 8'h00, q);
    m = q;
    repeat (32) @(negedge clk);
    hreq(1'b0, mhpc_pkg::ADDR_MDCCNT, 8'h00, q);
    chk("mdcRate", 8'h01, {7'h00, (q - m >= 8'h02) && (q - m <= 8'h03)});
  endtask
  // Consecutive received bytes count up from the seed
  task automatic t_rx();
    logic [7:0] q, first;
    int n;
    hreq(1'b1, mhpc_pkg::ADDR_RXSEED, 8'h40, q);
    hreq(1'b1, mhpc_pkg::ADDR_MODE, 8'h04, q);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (rxStrobe !== 1'b1 && n < 40);
      chk("rxStrobe", 8'h01, {7'h00, rxStrobe});
      first = q;
      q = rxByte;
    end
    chk("rxNext", first + 8'h01, q);
  endtask
  // Count rx data updates over a window at one speed and option
  task automatic t_rate(input logic [1:0] sp, input logic ad, input int win, input int lo,
      input int hi);
    logic [7:0] q, prev;
    int c;
    @(negedge clk);
    speed = sp;
    adaptMode = ad;
    hreq(1'b1, mhpc_pkg::ADDR_MODE, {6'h01, ad, 1'h0}, q);
    chk("adaptMode", {7'h00, ad}, {7'h00, devAdapt});
    repeat (100) @(negedge clk);
    c = 0;
    prev = bus.rxData;
    repeat (win) begin
      @(negedge clk);
      if (bus.rxData !== prev) c++;
      prev = bus.rxData;
    end
    chk("rateOk", 8'h01, {7'h00, c >= lo && c <= hi});
  endtask
  // Reset in mid-run clears registers and idles the bus
  task automatic t_reset();
    logic [7:0] q;
    hreq(1'b1, mhpc_pkg::ADDR_RXSEED, 8'h5a, q);
    @(negedge clk);
    rst_n = 1'b0;
    speed = 2'h0;
    adaptMode = 1'b0;
    @(negedge clk);
    chk("resetIdle", 8'h03, {6'h00, bus.hreadyN, bus.hdataoutEnN});
    chk("reqReady", 8'h01, {7'h00, reqReady});
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    hreq(1'b0, mhpc_pkg::ADDR_RXSEED, 8'h00, q);
    chk("seedClear", 8'h00, q);
    hreq(1'b0, mhpc_pkg::ADDR_MODE, 8'h00, q);
    chk("modeClear", mhpc_pkg::MODE_RESET, q);
  endtask
  // Three tx bytes, last with end of frame, then read-only last byte and count registers
  task automatic t_tx();
    logic [8:0] ex[3] = '{9'h011, 9'h022, 9'h133};
    logic [7:0] q;
    int n;
    @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      txValid = 1'b1;
      txByteIn = ex[i][7:0];
      txEofIn = ex[i][8];
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (txTaken !== 1'b1 && n < 60);
    end
    txValid = 1'b0;
    repeat (40) @(negedge clk);
    chk("txCount", 8'h03, 8'(txq.size()));
    for (int i = 0; i < 3; i++) begin
      chk("txByte", ex[i][7:0], txq[i][7:0]);
      chk("txEnd", {7'h00, ex[i][8]}, {7'h00, txq[i][8]});
    end
    hreq(1'b1, mhpc_pkg::ADDR_TXLAST, 8'h00, q);
    hreq(1'b0, mhpc_pkg::ADDR_TXLAST, 8'h00, q);
    chk("txLast", 8'h33, q);
    hreq(1'b0, mhpc_pkg::ADDR_TXCNT, 8'h00, q);
    chk("txCnt", 8'h03, q);
  endtask
  // Write strobe without select on the second device, then a selected read
  task automatic t_sel();
    int n;
    @(negedge clk);
    bus2.haddr = mhpc_pkg::ADDR_RXSEED;
    bus2.hdatain = 8'h77;
    bus2.hwriteN = 1'b0;
    repeat (6) begin
      @(negedge clk);
      chk("deselReady", 8'h01, {7'h00, bus2.hreadyN});
    end
    bus2.hwriteN = 1'b1;
    bus2.hcsN = 1'b0;
    bus2.hreadN = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bus2.hreadyN !== 1'b0 && n < 20);
    chk("selRead", 8'h00, bus2.hdataout);
    chk("dataEn", 8'h00, {7'h00, bus2.hdataoutEnN});
    bus2.hcsN = 1'b1;
    bus2.hreadN = 1'b1;
    repeat (3) @(negedge clk);
    chk("readyOff", 8'h01, {7'h00, bus2.hreadyN});
  endtask
  // Main sequence
  initial begin
    bus2.hcsN = 1'b1;
    bus2.hwriteN = 1'b1;
    bus2.hreadN = 1'b1;
    bus2.haddr = 8'h00;
    bus2.hdatain = 8'h00;
    // Reset edge after time zero so the async flops see it
    #1;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_rx();
    t_rate(2'h0, 1'b0, 800, 99, 101);
    t_rate(2'h0, 1'b1, 800, 99, 101);
    t_rate(2'h1, 1'b1, 800, 9, 11);
    t_rate(2'h2, 1'b1, 4000, 4, 6);
    t_rate(2'h1, 1'b0, 800, 9, 11);
    t_rate(2'h2, 1'b0, 4000, 4, 6);
    t_reset();
    t_tx();
    t_sel();
    tallyAndFinish();
  end
endmodule
